// file: rtl/ldm_defs.svh
// Register map, field positions, reset values and word packing of the LED diagnostic mask block
`ifndef LDM_DEFS_SVH
`define LDM_DEFS_SVH

// Register byte offsets
`define LDM_OFF_CTRL      8'h00
`define LDM_OFF_LOCK      8'h04
`define LDM_OFF_SH_MASK   8'h08
`define LDM_OFF_SL_MASK   8'h0c
`define LDM_OFF_OP_MASK   8'h10
`define LDM_OFF_ON_MASK   8'h14
`define LDM_OFF_LEVEL0    8'h20
`define LDM_OFF_LEVEL1    8'h24
`define LDM_OFF_LEVEL2    8'h28
`define LDM_OFF_SRC0      8'h30
`define LDM_OFF_SRC1      8'h34
`define LDM_OFF_PWM1      8'h40
`define LDM_OFF_PWM6      8'h54
`define LDM_OFF_STATUS    8'h60
`define LDM_OFF_INT_STAT  8'h64
`define LDM_OFF_INT_MASK  8'h68
`define LDM_OFF_CMD       8'h6c

// Control register fields
`define LDM_CTRL_THR_LO   0
`define LDM_CTRL_THR_HI   1
`define LDM_CTRL_CURRENT_SET_RESISTOR_PIN     2
`define LDM_CTRL_SH       3
`define LDM_CTRL_SL       4
`define LDM_CTRL_OP       5
`define LDM_CTRL_AJ       6
`define LDM_CTRL_W        7
`define LDM_CTRL_RST      7'h7f

// Command register fields
`define LDM_CMD_CLR_FLAG  0
`define LDM_CMD_SW_RESET  1

// Interrupt status fields
`define LDM_INT_FAULT     0
`define LDM_INT_REFUSED   1
`define LDM_INT_W         2

// Reset values of output group registers
`define LDM_OUT_MASK_RST  12'hfff
`define LDM_ON_MASK_RST   12'h000

// Packing of per-output fields into words
`define LDM_LEVEL_PER_WORD 4
`define LDM_SRC_PER_WORD   8
`define LDM_SRC_STRIDE     4
`define LDM_PWM_STRIDE     8'h04

`endif

// file: rtl/ldm_pkg.sv
// Types shared by the LED diagnostic mask block
package ldm_pkg;

  // Supply threshold select codes
  typedef enum logic [1:0] {
    LDM_THR_OFF   = 2'h0,
    LDM_THR_UPPER = 2'h1,
    LDM_THR_LOWER = 2'h2,
    LDM_THR_BOTH  = 2'h3
  } ldm_thr_t;

  // Duty source select codes
  typedef logic [2:0] ldm_src_t;

endpackage

// file: rtl/ldm_out_if.sv
// Bundle between the register bank and one output selector
`timescale 1ns/100ps
`default_nettype none

interface ldm_out_if #(
  parameter int LVL_W = 8,
  parameter int PWM_W = 10,
  parameter int PWM_N = 6
);
  import ldm_pkg::*;
  logic                   on_mask;
  logic [LVL_W-1:0]       level;
  ldm_src_t               src;
  logic [PWM_N*PWM_W-1:0] pwm;
  logic                   drive_on;
  logic [LVL_W-1:0]       drive_level;
  logic [PWM_W-1:0]       duty;
  logic                   duty_full;

  modport bank (output on_mask, level, src, pwm, input drive_on, drive_level, duty, duty_full);
  modport sel  (input on_mask, level, src, pwm, output drive_on, drive_level, duty, duty_full);
endinterface

`default_nettype wire

// file: rtl/ldm_out_sel.sv
// Per-output gate, current level and duty source selection
`timescale 1ns/100ps
`default_nettype none

module ldm_out_sel
  import ldm_pkg::*;
#(
  parameter int LVL_W = 8,
  parameter int PWM_W = 10,
  parameter int PWM_N = 6
) (
  input  wire logic pclk,
  input  wire logic presetn,
  ldm_out_if.sel    io
);

  initial begin
    if (PWM_N != 6) $error("ldm_out_sel: three-bit source select serves six channels");
  end

  // Output gate and current level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io.drive_on    <= 1'b0;
      io.drive_level <= '0;
    end else begin
      io.drive_on    <= io.on_mask;
      io.drive_level <= io.level;
    end
  end

  // Duty source: codes 0 and 7 run full duty, others pick a channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io.duty      <= '0;
      io.duty_full <= 1'b1;
    end else if (io.src == 3'h0 || io.src == 3'h7) begin
      io.duty      <= '1;
      io.duty_full <= 1'b1;
    end else begin
      io.duty      <= io.pwm[(32'(io.src) - 1) * PWM_W +: PWM_W];
      io.duty_full <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: rtl/ldm_top.sv
// APB register bank for LED output masks, diagnostic masks and duty source selection
`timescale 1ns/100ps
`default_nettype none
`include "ldm_defs.svh"

module ldm_top
  import ldm_pkg::*;
#(
  parameter int N_OUT = 12,
  parameter int LVL_W = 8,
  parameter int PWM_W = 10,
  parameter int PWM_N = 6
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   voltage_detect_reset,
  input  wire logic                   thermal_shutdown,
  input  wire logic                   supply_below_upper,
  input  wire logic                   supply_below_lower,
  output logic                        supply_fault_flag,
  output logic                        current_set_resistor_pin_check_enable,
  output logic      [N_OUT-1:0]       supply_short_det_en,
  output logic      [N_OUT-1:0]       ground_short_det_en,
  output logic      [N_OUT-1:0]       open_load_det_en,
  output logic                        adjacent_short_det_en,
  output logic      [N_OUT-1:0]       led_drive_on,
  output logic      [N_OUT*LVL_W-1:0] led_drive_level,
  output logic      [N_OUT*PWM_W-1:0] led_duty,
  output logic      [N_OUT-1:0]       led_duty_full,
  output logic                        irq
);

  localparam int N_SYNC = 4;

  initial begin
    if (N_OUT != 12) $error("ldm_top: register packing serves twelve outputs");
    if (LVL_W != 8) $error("ldm_top: current level field is eight bits");
    if (PWM_W > 16 || PWM_N != 6) $error("ldm_top: PWM width or channel count unsupported");
  end

  // Register state
  logic [`LDM_CTRL_W-1:0]   ctrl;
  logic                     locked;
  logic [N_OUT-1:0]         supply_short_output_mask;
  logic [N_OUT-1:0]         ground_short_output_mask;
  logic [N_OUT-1:0]         open_load_output_mask;
  logic [N_OUT-1:0]         output_on_mask;
  logic [N_OUT*LVL_W-1:0]   level;
  logic [N_OUT*3-1:0]       src;
  logic [PWM_N*PWM_W-1:0]   pwm;
  logic [`LDM_INT_W-1:0]    int_stat;
  logic [`LDM_INT_W-1:0]    int_mask;

  // Input synchronisers and filtered levels
  logic [N_SYNC-1:0] sync1;
  logic [N_SYNC-1:0] sync2;
  logic [N_SYNC-1:0] sync3;
  logic [N_SYNC-1:0] pin_level;

  // Bus decode
  logic setup;
  logic wr;
  logic mapped;
  logic protected_wr;
  logic refused;
  logic clr_flag;
  logic sw_reset;
  logic ctrl_reset;
  logic voltage_detect_reset_level;
  logic tsd_level;
  logic fault_event;
  logic [31:0] next_prdata;
  ldm_thr_t thr;

  // Three-stage synchronisers for asynchronous pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {supply_below_lower, supply_below_upper, thermal_shutdown, voltage_detect_reset};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A pin change counts once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level <= '0;
    end else begin
      for (int i = 0; i < N_SYNC; i++) begin
        if (sync2[i] == sync3[i]) begin
          pin_level[i] <= sync3[i];
        end
      end
    end
  end

  assign voltage_detect_reset_level = pin_level[0];
  assign tsd_level  = pin_level[1];

  // APB phase decode; lock guards threshold and detection masks
  assign setup        = psel && !penable;
  assign wr           = psel && penable && pwrite;
  assign protected_wr = wr && (paddr == `LDM_OFF_CTRL || paddr == `LDM_OFF_SH_MASK
                              || paddr == `LDM_OFF_SL_MASK || paddr == `LDM_OFF_OP_MASK);
  assign refused      = protected_wr && locked;
  assign clr_flag     = wr && paddr == `LDM_OFF_CMD && pwdata[`LDM_CMD_CLR_FLAG];
  assign sw_reset     = wr && paddr == `LDM_OFF_CMD && pwdata[`LDM_CMD_SW_RESET];
  assign ctrl_reset   = sw_reset || voltage_detect_reset_level || tsd_level;
  assign thr          = ldm_thr_t'({ctrl[`LDM_CTRL_THR_HI], ctrl[`LDM_CTRL_THR_LO]});

  // Lock state toggled by lock and unlock commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked <= 1'b0;
    end else if (voltage_detect_reset_level) begin
      locked <= 1'b0;
    end else if (wr && paddr == `LDM_OFF_LOCK) begin
      locked <= pwdata[0];
    end
  end

  // Protected control word: threshold select and master masks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `LDM_CTRL_RST;
    end else if (ctrl_reset) begin
      ctrl <= `LDM_CTRL_RST;
    end else if (wr && paddr == `LDM_OFF_CTRL && !locked) begin
      ctrl <= pwdata[`LDM_CTRL_W-1:0];
    end
  end

  // Protected per-output detection masks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_short_output_mask <= `LDM_OUT_MASK_RST;
      ground_short_output_mask <= `LDM_OUT_MASK_RST;
      open_load_output_mask    <= `LDM_OUT_MASK_RST;
    end else if (wr && !locked) begin
      if (paddr == `LDM_OFF_SH_MASK) begin
        supply_short_output_mask <= pwdata[N_OUT-1:0];
      end
      if (paddr == `LDM_OFF_SL_MASK) begin
        ground_short_output_mask <= pwdata[N_OUT-1:0];
      end
      if (paddr == `LDM_OFF_OP_MASK) begin
        open_load_output_mask <= pwdata[N_OUT-1:0];
      end
    end
  end

  // Output on masks, current levels, duty sources and PWM duty values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_on_mask <= `LDM_ON_MASK_RST;
      level          <= '0;
      src            <= '0;
      pwm            <= '0;
    end else if (wr) begin
      if (paddr == `LDM_OFF_ON_MASK) begin
        output_on_mask <= pwdata[N_OUT-1:0];
      end
      for (int w = 0; w < 3; w++) begin
        if (paddr == `LDM_OFF_LEVEL0 + 8'(4 * w)) begin
          level[w*32 +: 32] <= pwdata;
        end
      end
      for (int w = 0; w < 2; w++) begin
        if (paddr == `LDM_OFF_SRC0 + 8'(4 * w)) begin
          for (int k = 0; k < 6; k++) begin
            src[(w*6+k)*3 +: 3] <= pwdata[k*`LDM_SRC_STRIDE +: 3];
          end
        end
      end
      for (int c = 0; c < PWM_N; c++) begin
        if (paddr == `LDM_OFF_PWM1 + 8'(c) * `LDM_PWM_STRIDE) begin
          pwm[c*PWM_W +: PWM_W] <= pwdata[PWM_W-1:0];
        end
      end
    end
  end

  // Undervoltage comparison by threshold select
  always_comb begin
    fault_event = 1'b0;
    unique case (thr)
      LDM_THR_OFF:   fault_event = 1'b0;
      LDM_THR_UPPER: fault_event = pin_level[2];
      LDM_THR_LOWER: fault_event = pin_level[3];
      LDM_THR_BOTH:  fault_event = pin_level[2];
    endcase
  end

  // Sticky supply fault flag; a new event beats the clear command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_fault_flag <= 1'b1;
    end else if (fault_event || voltage_detect_reset_level) begin
      supply_fault_flag <= 1'b1;
    end else if (clr_flag) begin
      supply_fault_flag <= 1'b0;
    end
  end

  // Interrupt status, set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= '0;
      int_mask <= '0;
    end else begin
      if (wr && paddr == `LDM_OFF_INT_MASK) begin
        int_mask <= pwdata[`LDM_INT_W-1:0];
      end
      for (int i = 0; i < `LDM_INT_W; i++) begin
        if ((i == `LDM_INT_FAULT && fault_event) || (i == `LDM_INT_REFUSED && refused)) begin
          int_stat[i] <= 1'b1;
        end else if (wr && paddr == `LDM_OFF_INT_STAT && pwdata[i]) begin
          int_stat[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  // Detection enables from master and per-output masks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_set_resistor_pin_check_enable     <= 1'b1;
      supply_short_det_en   <= '0;
      ground_short_det_en   <= '0;
      open_load_det_en      <= '0;
      adjacent_short_det_en <= 1'b1;
    end else begin
      current_set_resistor_pin_check_enable     <= ctrl[`LDM_CTRL_CURRENT_SET_RESISTOR_PIN];
      supply_short_det_en   <= {N_OUT{ctrl[`LDM_CTRL_SH]}} & supply_short_output_mask;
      ground_short_det_en   <= {N_OUT{ctrl[`LDM_CTRL_SL]}} & ground_short_output_mask;
      open_load_det_en      <= {N_OUT{ctrl[`LDM_CTRL_OP]}} & open_load_output_mask;
      adjacent_short_det_en <= ctrl[`LDM_CTRL_AJ];
    end
  end

  // Read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    mapped      = 1'b1;
    unique case (paddr)
      `LDM_OFF_CTRL:     next_prdata[`LDM_CTRL_W-1:0] = ctrl;
      `LDM_OFF_LOCK:     next_prdata[0] = locked;
      `LDM_OFF_SH_MASK:  next_prdata[N_OUT-1:0] = supply_short_output_mask;
      `LDM_OFF_SL_MASK:  next_prdata[N_OUT-1:0] = ground_short_output_mask;
      `LDM_OFF_OP_MASK:  next_prdata[N_OUT-1:0] = open_load_output_mask;
      `LDM_OFF_ON_MASK:  next_prdata[N_OUT-1:0] = output_on_mask;
      `LDM_OFF_LEVEL0:   next_prdata = level[31:0];
      `LDM_OFF_LEVEL1:   next_prdata = level[63:32];
      `LDM_OFF_LEVEL2:   next_prdata = level[95:64];
      `LDM_OFF_SRC0, `LDM_OFF_SRC1: begin
        for (int k = 0; k < 6; k++) begin
          next_prdata[k*`LDM_SRC_STRIDE +: 3] = src[((paddr == `LDM_OFF_SRC1 ? 6 : 0) + k)*3 +: 3];
        end
      end
      `LDM_OFF_STATUS:   next_prdata[0] = supply_fault_flag;
      `LDM_OFF_INT_STAT: next_prdata[`LDM_INT_W-1:0] = int_stat;
      `LDM_OFF_INT_MASK: next_prdata[`LDM_INT_W-1:0] = int_mask;
      `LDM_OFF_CMD:      next_prdata = 32'h0000_0000;
      default: begin
        mapped = 1'b0;
        for (int c = 0; c < PWM_N; c++) begin
          if (paddr == `LDM_OFF_PWM1 + 8'(c) * `LDM_PWM_STRIDE) begin
            next_prdata[PWM_W-1:0] = pwm[c*PWM_W +: PWM_W];
            mapped = 1'b1;
          end
        end
      end
    endcase
  end

  // Answer registered in the setup cycle; zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= !mapped || (pwrite && locked && (paddr == `LDM_OFF_CTRL || paddr == `LDM_OFF_SH_MASK
                   || paddr == `LDM_OFF_SL_MASK || paddr == `LDM_OFF_OP_MASK));
      end
    end
  end

  // One selector per output
  for (genvar g = 0; g < N_OUT; g++) begin : g_out
    ldm_out_if #(.LVL_W(LVL_W), .PWM_W(PWM_W), .PWM_N(PWM_N)) oif ();
    assign oif.on_mask = output_on_mask[g];
    assign oif.level   = level[g*LVL_W +: LVL_W];
    assign oif.src     = src[g*3 +: 3];
    assign oif.pwm     = pwm;
    assign led_drive_on[g]                  = oif.drive_on;
    assign led_drive_level[g*LVL_W +: LVL_W] = oif.drive_level;
    assign led_duty[g*PWM_W +: PWM_W]       = oif.duty;
    assign led_duty_full[g]                 = oif.duty_full;
    ldm_out_sel #(.LVL_W(LVL_W), .PWM_W(PWM_W), .PWM_N(PWM_N)) u_sel (
      .pclk    (pclk),
      .presetn (presetn),
      .io      (oif)
    );
  end

endmodule

`default_nettype wire

// file: tb/ldm_supply_model.sv
// Comparator model of the LED pull-up supply seen by the mask block
`timescale 1ns/100ps
`default_nettype none

module ldm_supply_model #(
  parameter int UPPER_MV = 4200,
  parameter int LOWER_MV = 2400
) (
  input  wire logic [15:0] supply_mv,
  output logic             supply_below_upper,
  output logic             supply_below_lower
);
  // Level flags follow the supply at or below each threshold
  assign supply_below_upper = (supply_mv <= UPPER_MV);
  assign supply_below_lower = (supply_mv <= LOWER_MV);
endmodule

`default_nettype wire

// file: tb/ldm_top_assertions.sv
// Port-level checks for the LED diagnostic mask block
`timescale 1ns/100ps
`default_nettype none
`include "ldm_defs.svh"

module ldm_top_assertions #(
  parameter int N_OUT = 12,
  parameter int PWM_W = 10
) (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   voltage_detect_reset,
  input wire logic                   thermal_shutdown,
  input wire logic                   supply_fault_flag,
  input wire logic                   current_set_resistor_pin_check_enable,
  input wire logic                   adjacent_short_det_en,
  input wire logic [N_OUT*PWM_W-1:0] led_duty,
  input wire logic [N_OUT-1:0]       led_duty_full
);
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus answers with no wait state and flags unmapped places
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("access without ready");
  chk_unmapped_err: assert property (psel && penable && paddr[7] |-> pslverr)
    else $error("unmapped access without error");
  chk_cmd_reads_zero: assert property (psel && penable && !pwrite && paddr == `LDM_OFF_CMD |-> prdata == 32'h0000_0000)
    else $error("command register read not zero");
  chk_status_read: assert property (psel && penable && !pwrite && paddr == `LDM_OFF_STATUS
    |-> prdata == {31'h0000_0000, $past(supply_fault_flag)}) else $error("status read mismatch");

  // Fault flag only falls after the clear command
  chk_fault_sticky: assert property ($fell(supply_fault_flag)
    |-> $past(psel && penable && pwrite && paddr == `LDM_OFF_CMD && pwdata[0])) else $error("fault flag lost");

  // Held reset events restore the control bits; a held voltage detect sets the fault flag
  chk_event_restore: assert property ((thermal_shutdown || voltage_detect_reset) [*8]
    |-> current_set_resistor_pin_check_enable && adjacent_short_det_en) else $error("control not restored");
  chk_voltage_detect_reset_flag: assert property (voltage_detect_reset [*8] |-> supply_fault_flag)
    else $error("fault flag not set by voltage detect");

  // Full duty shows as an all ones duty value
  for (genvar i = 0; i < N_OUT; i++) begin : g_full
    chk_full_ones: assert property ($past(presetn, 2) && led_duty_full[i]
      |-> led_duty[i*PWM_W +: PWM_W] == {PWM_W{1'b1}}) else $error("full duty value wrong");
  end
endmodule

bind ldm_top ldm_top_assertions #(.N_OUT(N_OUT), .PWM_W(PWM_W)) i_ldm_top_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .voltage_detect_reset(voltage_detect_reset), .thermal_shutdown(thermal_shutdown),
  .supply_fault_flag(supply_fault_flag), .current_set_resistor_pin_check_enable(current_set_resistor_pin_check_enable),
  .adjacent_short_det_en(adjacent_short_det_en), .led_duty(led_duty), .led_duty_full(led_duty_full));

`default_nettype wire

// file: tb/tb.sv
// Register level testbench of the LED diagnostic mask block
`timescale 1ns/100ps
`default_nettype none
`include "ldm_defs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end

module tb;
  import ldm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        voltage_detect_reset, thermal_shutdown, supply_below_upper, supply_below_lower;
  logic        supply_fault_flag, current_set_resistor_pin_check_enable, adjacent_short_det_en, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] supply_mv;
  logic [11:0] supply_short_det_en, ground_short_det_en, open_load_det_en, led_drive_on, led_duty_full;
  logic [95:0] led_drive_level;
  logic [119:0] led_duty;
  ldm_src_t    code;
  int          miscompares, cmp_count, k, i;
  ldm_src_t    src_tab [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 1, 2, 3, 4};
  logic        exp_mid [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic        exp_low [4] = '{1'b0, 1'b1, 1'b1, 1'b1};

  ldm_top i_ldm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .voltage_detect_reset(voltage_detect_reset), .thermal_shutdown(thermal_shutdown),
    .supply_below_upper(supply_below_upper), .supply_below_lower(supply_below_lower),
    .supply_fault_flag(supply_fault_flag), .current_set_resistor_pin_check_enable(current_set_resistor_pin_check_enable),
    .supply_short_det_en(supply_short_det_en), .ground_short_det_en(ground_short_det_en),
    .open_load_det_en(open_load_det_en), .adjacent_short_det_en(adjacent_short_det_en),
    .led_drive_on(led_drive_on), .led_drive_level(led_drive_level), .led_duty(led_duty),
    .led_duty_full(led_duty_full), .irq(irq));
  ldm_supply_model i_ldm_supply_model (.supply_mv(supply_mv), .supply_below_upper(supply_below_upper),
    .supply_below_lower(supply_below_lower));

  // Clock generator
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the ready edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 1;
    @(posedge pclk);
    // Ready is looked at only on rising edges, request held until then
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      miscompares++;
      results();
    end else begin
      rdata   = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, voltage_detect_reset, thermal_shutdown} = '0;
    {presetn, miscompares, cmp_count} = '0;
    supply_mv = 16'h1388;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wt(8);
    acc(1'b0, `LDM_OFF_CTRL, 32'h0); `CHK("ctrl", 32'h0000_007f, rdata)
    acc(1'b0, `LDM_OFF_SH_MASK, 32'h0); `CHK("sh mask", 32'h0000_0fff, rdata)
    acc(1'b0, `LDM_OFF_ON_MASK, 32'h0); `CHK("on mask", 32'h0000_0000, rdata)
    acc(1'b0, `LDM_OFF_CMD, 32'h0); `CHK("cmd", 32'h0000_0000, rdata)
    acc(1'b0, 8'h80, 32'h0); `CHK("unmapped err", 1'b1, rerr)
    `CHK("sh det", 12'hfff, supply_short_det_en)
    $display("Test reset finished");
    // Masters off, then per-output masks under masters on
    acc(1'b1, `LDM_OFF_CTRL, 32'h0000_0003);
    wt(4);
    `CHK("current_set_resistor_pin", 1'b0, current_set_resistor_pin_check_enable)
    `CHK("adj", 1'b0, adjacent_short_det_en)
    `CHK("sh off", 12'h000, supply_short_det_en)
    `CHK("sl off", 12'h000, ground_short_det_en)
    `CHK("op off", 12'h000, open_load_det_en)
    acc(1'b1, `LDM_OFF_SH_MASK, 32'h0000_00a5);
    acc(1'b1, `LDM_OFF_SL_MASK, 32'h0000_05a0);
    acc(1'b1, `LDM_OFF_OP_MASK, 32'h0000_000f);
    acc(1'b1, `LDM_OFF_CTRL, 32'h0000_007f);
    wt(4);
    `CHK("sh on", 12'h0a5, supply_short_det_en)
    `CHK("sl on", 12'h5a0, ground_short_det_en)
    `CHK("op on", 12'h00f, open_load_det_en)
    `CHK("current_set_resistor_pin on", 1'b1, current_set_resistor_pin_check_enable)
    `CHK("adj on", 1'b1, adjacent_short_det_en)
    $display("Test masks finished");
    // Locked writes are refused and raise the interrupt
    acc(1'b1, `LDM_OFF_INT_STAT, 32'h0000_0003);
    acc(1'b1, `LDM_OFF_INT_MASK, 32'h0000_0002);
    acc(1'b1, `LDM_OFF_LOCK, 32'h0000_0001);
    acc(1'b1, `LDM_OFF_CTRL, 32'h0); `CHK("locked err", 1'b1, rerr)
    acc(1'b1, `LDM_OFF_SH_MASK, 32'h0); `CHK("locked mask err", 1'b1, rerr)
    acc(1'b0, `LDM_OFF_CTRL, 32'h0); `CHK("ctrl kept", 32'h0000_007f, rdata)
    wt(4);
    `CHK("irq set", 1'b1, irq)
    acc(1'b1, `LDM_OFF_INT_STAT, 32'h0000_0002);
    wt(4);
    `CHK("irq clr", 1'b0, irq)
    acc(1'b1, `LDM_OFF_INT_MASK, 32'h0);
    acc(1'b1, `LDM_OFF_CTRL, 32'h0);
    wt(4);
    `CHK("irq masked", 1'b0, irq)
    acc(1'b1, `LDM_OFF_LOCK, 32'h0);
    acc(1'b1, `LDM_OFF_CTRL, 32'h0000_007c); `CHK("unlocked err", 1'b0, rerr)
    acc(1'b0, `LDM_OFF_CTRL, 32'h0); `CHK("ctrl new", 32'h0000_007c, rdata)
    $display("Test lock finished");
    // Every threshold code against mid and low supply
    for (k = 0; k < 4; k++) begin
      acc(1'b1, `LDM_OFF_CTRL, 32'h0000_007c | 32'(k));
      supply_mv <= 16'h1388;
      wt(8);
      acc(1'b1, `LDM_OFF_CMD, 32'h0000_0001);
      acc(1'b0, `LDM_OFF_STATUS, 32'h0); `CHK("flag clr", 32'h0, rdata)
      supply_mv <= 16'h0ce4;
      wt(8);
      acc(1'b0, `LDM_OFF_STATUS, 32'h0); `CHK("flag mid", {31'h0, exp_mid[k]}, rdata)
      supply_mv <= 16'h07d0;
      wt(8);
      acc(1'b0, `LDM_OFF_STATUS, 32'h0); `CHK("flag low", {31'h0, exp_low[k]}, rdata)
      supply_mv <= 16'h1388;
      wt(8);
      acc(1'b0, `LDM_OFF_STATUS, 32'h0); `CHK("flag held", {31'h0, exp_low[k]}, rdata)
    end
    $display("Test threshold finished");
    // Output gate, level and every duty source code
    acc(1'b1, `LDM_OFF_ON_MASK, 32'h0000_0801);
    acc(1'b1, `LDM_OFF_LEVEL0, 32'h4433_2211);
    acc(1'b1, `LDM_OFF_LEVEL2, 32'hcc00_0000);
    for (k = 0; k < 6; k++) acc(1'b1, `LDM_OFF_PWM1 + 8'(4 * k), 32'h0000_0101 + 32'(k));
    acc(1'b1, `LDM_OFF_SRC0, 32'h0054_3210);
    acc(1'b1, `LDM_OFF_SRC1, 32'h0043_2176);
    wt(4);
    `CHK("drive on", 12'h801, led_drive_on)
    `CHK("level 0", 8'h11, led_drive_level[7:0])
    `CHK("level 11", 8'hcc, led_drive_level[95:88])
    for (i = 0; i < 12; i++) begin
      code = src_tab[i];
      `CHK("full", (code == 3'h0 || code == 3'h7), led_duty_full[i])
      `CHK("duty", (code == 3'h0 || code == 3'h7) ? 10'h3ff : 10'h100 + 10'(code), led_duty[i*10 +: 10])
    end
    $display("Test outputs finished");
    // Thermal, software and voltage-detect restore
    acc(1'b1, `LDM_OFF_CTRL, 32'h0);
    acc(1'b1, `LDM_OFF_LOCK, 32'h0000_0001);
    thermal_shutdown <= 1'b1;
    wt(10);
    thermal_shutdown <= 1'b0;
    wt(6);
    acc(1'b0, `LDM_OFF_CTRL, 32'h0); `CHK("thermal ctrl", 32'h0000_007f, rdata)
    acc(1'b0, `LDM_OFF_LOCK, 32'h0); `CHK("thermal lock", 32'h0000_0001, rdata)
    acc(1'b1, `LDM_OFF_LOCK, 32'h0);
    acc(1'b1, `LDM_OFF_CTRL, 32'h0);
    acc(1'b1, `LDM_OFF_CMD, 32'h0000_0002);
    acc(1'b0, `LDM_OFF_CTRL, 32'h0); `CHK("soft ctrl", 32'h0000_007f, rdata)
    acc(1'b1, `LDM_OFF_CTRL, 32'h0);
    acc(1'b1, `LDM_OFF_LOCK, 32'h0000_0001);
    acc(1'b1, `LDM_OFF_CMD, 32'h0000_0001);
    acc(1'b0, `LDM_OFF_STATUS, 32'h0); `CHK("pre voltage_detect_reset flag", 32'h0000_0000, rdata)
    voltage_detect_reset <= 1'b1;
    wt(10);
    voltage_detect_reset <= 1'b0;
    wt(6);
    acc(1'b0, `LDM_OFF_CTRL, 32'h0); `CHK("voltage_detect_reset ctrl", 32'h0000_007f, rdata)
    acc(1'b0, `LDM_OFF_LOCK, 32'h0); `CHK("voltage_detect_reset lock", 32'h0000_0000, rdata)
    acc(1'b0, `LDM_OFF_STATUS, 32'h0); `CHK("voltage_detect_reset flag", 32'h0000_0001, rdata)
    // Reset pin in mid-run restores control and clears the on masks
    acc(1'b1, `LDM_OFF_CTRL, 32'h0);
    presetn <= 1'b0;
    wt(3);
    presetn <= 1'b1;
    wt(2);
    acc(1'b0, `LDM_OFF_CTRL, 32'h0); `CHK("pin ctrl", 32'h0000_007f, rdata)
    acc(1'b0, `LDM_OFF_ON_MASK, 32'h0); `CHK("pin on mask", 32'h0000_0000, rdata)
    $display("Test restore finished");
    results();
  end
endmodule

`default_nettype wire
